// *** shared/t16oc_pkg.sv ***
// constants for the timer output compare channels
package t16oc_pkg;
  localparam int unsigned T16OC_DW = 16;
  localparam int unsigned T16OC_BW = 8;
  localparam int unsigned T16OC_NCH = 2;
  // byte register indexes on the cpu port
  localparam logic [3:0] T16OC_A_CNT_LO = 4'h0;
  localparam logic [3:0] T16OC_A_CNT_HI = 4'h1;
  localparam logic [3:0] T16OC_A_CMPA_LO = 4'h2;
  localparam logic [3:0] T16OC_A_CMPA_HI = 4'h3;
  localparam logic [3:0] T16OC_A_CMPB_LO = 4'h4;
  localparam logic [3:0] T16OC_A_CMPB_HI = 4'h5;
  localparam logic [3:0] T16OC_A_CTRL = 4'h6;
  localparam logic [3:0] T16OC_A_FLAG = 4'h7;
  localparam logic [3:0] T16OC_A_FORCE = 4'h8;
  localparam logic [3:0] T16OC_A_MODE = 4'h9;
  localparam logic [3:0] T16OC_A_CAP_LO = 4'hA;
  localparam logic [3:0] T16OC_A_CAP_HI = 4'hB;
  // ctrl byte: [1:0] action A, [3:2] action B, [5:4] irq enables
  localparam int unsigned T16OC_CTRL_ACT_B = 2;
  localparam int unsigned T16OC_CTRL_IEN = 4;
  localparam logic [7:0] T16OC_CTRL_RST = 8'h00;
  localparam logic [3:0] T16OC_MODE_RST = 4'h0;
  localparam logic [15:0] T16OC_ZERO = 16'h0000;
  localparam logic [15:0] T16OC_MAX = 16'hFFFF;
  localparam logic [15:0] T16OC_TOP8 = 16'h00FF;
  localparam logic [15:0] T16OC_TOP9 = 16'h01FF;
  localparam logic [15:0] T16OC_TOP10 = 16'h03FF;
  localparam logic [1:0] T16OC_ACT_NONE = 2'h0;
  localparam logic [1:0] T16OC_ACT_TOG = 2'h1;
  localparam logic [1:0] T16OC_ACT_CLR = 2'h2;
  localparam logic [1:0] T16OC_ACT_SET = 2'h3;
  localparam logic [3:0] T16OC_M_NORMAL = 4'h0;
  localparam logic [3:0] T16OC_M_PC8 = 4'h1;
  localparam logic [3:0] T16OC_M_PC9 = 4'h2;
  localparam logic [3:0] T16OC_M_PC10 = 4'h3;
  localparam logic [3:0] T16OC_M_CTC_A = 4'h4;
  localparam logic [3:0] T16OC_M_F8 = 4'h5;
  localparam logic [3:0] T16OC_M_F9 = 4'h6;
  localparam logic [3:0] T16OC_M_F10 = 4'h7;
  localparam logic [3:0] T16OC_M_PFC_C = 4'h8;
  localparam logic [3:0] T16OC_M_PFC_A = 4'h9;
  localparam logic [3:0] T16OC_M_PC_C = 4'hA;
  localparam logic [3:0] T16OC_M_PC_A = 4'hB;
  localparam logic [3:0] T16OC_M_CTC_C = 4'hC;
  localparam logic [3:0] T16OC_M_RSVD = 4'hD;
  localparam logic [3:0] T16OC_M_FC = 4'hE;
  localparam logic [3:0] T16OC_M_FA = 4'hF;
endpackage

// *** logic/t16oc_top.sv ***
// two output compare channels with their counter and byte-wide cpu port
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module t16oc_top #(
  parameter int unsigned DW = t16oc_pkg::T16OC_DW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic count_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] irq_ack,
  output logic [1:0] compare_irq,
  input wire logic [1:0] port_value,
  input wire logic [1:0] pin_direction_bit,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] compare_output_state,
  output logic [DW-1:0] timer_count,
  output logic counter_limit,
  output logic counter_floor
);
  typedef logic [DW-1:0] word_t;

  word_t count_reg;
  logic down_reg;
  logic [7:0] temp_reg;
  logic [7:0] ctrl_reg;
  logic [3:0] waveform_gen_select;
  logic [1:0] compare_match_flag;
  logic [1:0] oc_reg;
  logic block_reg;
  logic lim_skip_reg;
  word_t cap_reg;
  localparam int unsigned T16OC_NCH_L = t16oc_pkg::T16OC_NCH;
  word_t active_reg [T16OC_NCH_L];
  word_t buffer_reg [T16OC_NCH_L];
  word_t cpu_view [T16OC_NCH_L];

  // byte lanes of a word on the eight-bit port
  function automatic logic [7:0] hi_byte(input word_t w);
    hi_byte = w[DW-1 -: t16oc_pkg::T16OC_BW];
  endfunction

  function automatic logic [7:0] lo_byte(input word_t w);
    lo_byte = w[t16oc_pkg::T16OC_BW-1:0];
  endfunction

  // decode of mode classes, used in several places
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == t16oc_pkg::T16OC_M_NORMAL || m == t16oc_pkg::T16OC_M_CTC_A
      || m == t16oc_pkg::T16OC_M_CTC_C || m == t16oc_pkg::T16OC_M_RSVD);
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m == t16oc_pkg::T16OC_M_PC8) || (m == t16oc_pkg::T16OC_M_PC9)
      || (m == t16oc_pkg::T16OC_M_PC10) || (m >= t16oc_pkg::T16OC_M_PFC_C
      && m <= t16oc_pkg::T16OC_M_PC_A);
  endfunction

  function automatic logic is_var_top(input logic [3:0] m);
    is_var_top = (m == t16oc_pkg::T16OC_M_PFC_C) || (m == t16oc_pkg::T16OC_M_PFC_A)
      || (m == t16oc_pkg::T16OC_M_PC_C) || (m == t16oc_pkg::T16OC_M_PC_A)
      || (m == t16oc_pkg::T16OC_M_FC) || (m == t16oc_pkg::T16OC_M_FA)
      || (m == t16oc_pkg::T16OC_M_CTC_A) || (m == t16oc_pkg::T16OC_M_CTC_C);
  endfunction

  word_t top_val;
  always_comb
  begin
    unique case (waveform_gen_select)
      t16oc_pkg::T16OC_M_PC8, t16oc_pkg::T16OC_M_F8: top_val = t16oc_pkg::T16OC_TOP8;
      t16oc_pkg::T16OC_M_PC9, t16oc_pkg::T16OC_M_F9: top_val = t16oc_pkg::T16OC_TOP9;
      t16oc_pkg::T16OC_M_PC10, t16oc_pkg::T16OC_M_F10: top_val = t16oc_pkg::T16OC_TOP10;
      t16oc_pkg::T16OC_M_CTC_A, t16oc_pkg::T16OC_M_PFC_A, t16oc_pkg::T16OC_M_PC_A,
      t16oc_pkg::T16OC_M_FA: top_val = active_reg[0];
      t16oc_pkg::T16OC_M_PFC_C, t16oc_pkg::T16OC_M_PC_C, t16oc_pkg::T16OC_M_CTC_C,
      t16oc_pkg::T16OC_M_FC: top_val = cap_reg;
      default: top_val = t16oc_pkg::T16OC_MAX;
    endcase
  end

  logic pwm_mode;
  logic dual_mode;
  logic at_top;
  logic at_floor;
  logic [1:0] match;
  logic [1:0] live_match;
  logic cnt_wr;
  logic [3:0] a;
  assign pwm_mode = is_pwm(waveform_gen_select);
  assign dual_mode = is_dual(waveform_gen_select);
  assign at_top = (count_reg == top_val) && !lim_skip_reg;
  assign at_floor = (count_reg == t16oc_pkg::T16OC_ZERO);
  assign cnt_wr = reg_wr && (reg_addr == t16oc_pkg::T16OC_A_CNT_LO);
  assign a = reg_addr;

  // counter; a cpu write has priority over counting
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= t16oc_pkg::T16OC_ZERO;
      down_reg <= 1'b0;
    end
    else if (cnt_wr)
    begin
      count_reg <= {temp_reg, reg_wdata};
    end
    else if (count_tick)
    begin
      if (dual_mode)
      begin
        if (at_top && !down_reg)
        begin
          down_reg <= 1'b1;
          count_reg <= count_reg - 1'b1;
        end
        else if (down_reg && at_floor)
        begin
          down_reg <= 1'b0;
          count_reg <= count_reg + 1'b1;
        end
        else
        begin
          count_reg <= down_reg ? count_reg - 1'b1 : count_reg + 1'b1;
        end
      end
      else
      begin
        down_reg <= 1'b0;
        count_reg <= at_top ? t16oc_pkg::T16OC_ZERO : count_reg + 1'b1;
      end
    end
  end

  // count written equal to a variable pwm limit: limit match skipped until wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lim_skip_reg <= 1'b0;
    else if (cnt_wr)
      lim_skip_reg <= pwm_mode && is_var_top(waveform_gen_select)
        && ({temp_reg, reg_wdata} == top_val);
    else if (count_tick && count_reg == t16oc_pkg::T16OC_MAX)
      lim_skip_reg <= 1'b0;
  end

  // counter write blocks matches for one counter tick, even when stopped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      block_reg <= 1'b0;
    else if (cnt_wr)
      block_reg <= 1'b1;
    else if (count_tick)
      block_reg <= 1'b0;
  end

  // shared high byte latch; a count or capture low byte read freezes the high byte
  // one latch for all words: software must not interleave two 16-bit writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      temp_reg <= 8'h00;
    else if (reg_wr && (a == t16oc_pkg::T16OC_A_CNT_HI || a == t16oc_pkg::T16OC_A_CMPA_HI
      || a == t16oc_pkg::T16OC_A_CMPB_HI || a == t16oc_pkg::T16OC_A_CAP_HI))
      temp_reg <= reg_wdata;
    else if (reg_rd && (a == t16oc_pkg::T16OC_A_CNT_LO || a == t16oc_pkg::T16OC_A_CAP_LO))
      temp_reg <= (a == t16oc_pkg::T16OC_A_CNT_LO) ? hi_byte(count_reg) : hi_byte(cap_reg);
  end

  // limit register used by the capture-defined modes; low byte reads as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_reg <= t16oc_pkg::T16OC_ZERO;
    else if (reg_wr && a == t16oc_pkg::T16OC_A_CAP_LO)
      cap_reg <= {temp_reg, reg_wdata};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= t16oc_pkg::T16OC_CTRL_RST;
    else if (reg_wr && a == t16oc_pkg::T16OC_A_CTRL)
      ctrl_reg <= reg_wdata;
  end

  // mode change leaves the output states alone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      waveform_gen_select <= t16oc_pkg::T16OC_MODE_RST;
    else if (reg_wr && a == t16oc_pkg::T16OC_A_MODE)
      waveform_gen_select <= reg_wdata[3:0];
  end

  // loading only at the turn keeps every pwm period whole
  logic buf_load;
  assign buf_load = count_tick && (dual_mode ? (at_top && !down_reg) : at_top);

  genvar g;
  generate
    for (g = 0; g < T16OC_NCH_L; g++)
    begin : g_ch
      logic [3:0] lo_a;
      logic [1:0] act;
      logic lo_wr;
      logic force_hit;
      logic hit;
      logic next_oc;
      assign lo_a = (g == 0) ? t16oc_pkg::T16OC_A_CMPA_LO : t16oc_pkg::T16OC_A_CMPB_LO;
      assign act = ctrl_reg[t16oc_pkg::T16OC_CTRL_ACT_B * g +: 2];
      assign lo_wr = reg_wr && (a == lo_a);
      assign live_match[g] = (count_reg == active_reg[g]);
      assign match[g] = live_match[g] && !block_reg;
      assign force_hit = reg_wr && (a == t16oc_pkg::T16OC_A_FORCE) && reg_wdata[g]
        && !pwm_mode;
      assign cpu_view[g] = pwm_mode ? buffer_reg[g] : active_reg[g];

      // buffered or direct compare storage
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          active_reg[g] <= t16oc_pkg::T16OC_ZERO;
          buffer_reg[g] <= t16oc_pkg::T16OC_ZERO;
        end
        else
        begin
          if (lo_wr)
            buffer_reg[g] <= {temp_reg, reg_wdata};
          if (lo_wr && !pwm_mode)
            active_reg[g] <= {temp_reg, reg_wdata};
          else if (pwm_mode && buf_load)
            active_reg[g] <= buffer_reg[g];
        end
      end

      // set wins over clear; lands on the tick that ends the match cycle
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          compare_match_flag[g] <= 1'b0;
        else if (count_tick && match[g])
          compare_match_flag[g] <= 1'b1;
        else if (irq_ack[g] || (reg_wr && a == t16oc_pkg::T16OC_A_FLAG && reg_wdata[g]))
          compare_match_flag[g] <= 1'b0;
      end

      // waveform action per mode class
      always_comb
      begin
        next_oc = oc_reg[g];
        hit = (count_tick && match[g]) || force_hit;
        if (!pwm_mode)
        begin
          if (hit)
          begin
            unique case (act)
              t16oc_pkg::T16OC_ACT_NONE: next_oc = oc_reg[g];
              t16oc_pkg::T16OC_ACT_TOG: next_oc = !oc_reg[g];
              t16oc_pkg::T16OC_ACT_CLR: next_oc = 1'b0;
              t16oc_pkg::T16OC_ACT_SET: next_oc = 1'b1;
            endcase
          end
        end
        else if (act[1] && count_tick)
        begin
          // pwm: act[0] picks inverted form; single slope drives act[0] at the limit and its inverse on a match, dual slope moves only on matches
          if (dual_mode)
          begin
            if (match[g])
              next_oc = act[0] ^ down_reg;
          end
          else if (at_top)
            next_oc = act[0];
          else if (match[g])
            next_oc = !act[0];
        end
        else if (act == t16oc_pkg::T16OC_ACT_TOG && g == 0 && count_tick && match[g])
          next_oc = !oc_reg[g];
      end

      // kept across mode changes; only matches, forces and the pwm limit move it
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          oc_reg[g] <= 1'b0;
        else
          oc_reg[g] <= next_oc;
      end

      // port value shows while the action field is zero
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_out[g] <= 1'b0;
        else
          pin_out[g] <= (act != t16oc_pkg::T16OC_ACT_NONE) ? next_oc : port_value[g];
      end

      // direction stays with software even while the pin is overridden
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_oe[g] <= 1'b0;
        else
          pin_oe[g] <= pin_direction_bit[g];
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          compare_irq[g] <= 1'b0;
        else
          compare_irq[g] <= ctrl_reg[t16oc_pkg::T16OC_CTRL_IEN + g]
            && compare_match_flag[g];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      compare_output_state <= 2'h0;
    else
      compare_output_state <= oc_reg;
  end

  // counter view lags the count by one clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_count <= t16oc_pkg::T16OC_ZERO;
      counter_limit <= 1'b0;
      counter_floor <= 1'b0;
    end
    else
    begin
      timer_count <= count_reg;
      counter_limit <= at_top;
      counter_floor <= at_floor;
    end
  end

  // read data in the cycle after the strobe; compare reads are direct
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (a)
        t16oc_pkg::T16OC_A_CNT_LO: reg_rdata <= lo_byte(count_reg);
        t16oc_pkg::T16OC_A_CNT_HI: reg_rdata <= temp_reg;
        t16oc_pkg::T16OC_A_CMPA_LO: reg_rdata <= lo_byte(cpu_view[0]);
        t16oc_pkg::T16OC_A_CMPA_HI: reg_rdata <= hi_byte(cpu_view[0]);
        t16oc_pkg::T16OC_A_CMPB_LO: reg_rdata <= lo_byte(cpu_view[1]);
        t16oc_pkg::T16OC_A_CMPB_HI: reg_rdata <= hi_byte(cpu_view[1]);
        t16oc_pkg::T16OC_A_CTRL: reg_rdata <= ctrl_reg;
        t16oc_pkg::T16OC_A_FLAG: reg_rdata <= {6'h00, compare_match_flag};
        t16oc_pkg::T16OC_A_MODE: reg_rdata <= {4'h0, waveform_gen_select};
        t16oc_pkg::T16OC_A_CAP_HI: reg_rdata <= temp_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule

// *** bench/t16oc_checker.sv ***
// port assertions for the output compare block
`timescale 1ns/10ps
module t16oc_checker #(
  parameter int unsigned DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic count_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] irq_ack,
  input wire logic [1:0] compare_irq,
  input wire logic [1:0] port_value,
  input wire logic [1:0] pin_direction_bit,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] compare_output_state,
  input wire logic [DW-1:0] timer_count,
  input wire logic counter_limit,
  input wire logic counter_floor
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data seen outside its slot");
  a_oe_direction: assert property ($past(rst_n) |-> pin_oe == $past(pin_direction_bit))
    else $error("pin enable does not follow direction bit");
  a_state_reset: assert property ($rose(rst_n) |-> compare_output_state == 2'h0)
    else $error("output state not cleared by reset");
  a_floor_zero: assert property ($past(rst_n) |-> counter_floor == (timer_count == '0))
    else $error("floor indication disagrees with count");
  a_irq_cause: assert property ($rose(compare_irq[0]) |->
    $past(count_tick, 2) || $past(reg_wr, 2) || $past(reg_wr))
    else $error("interrupt rose without tick or write");
  a_irq_clear: assert property ($fell(compare_irq[0]) |->
    $past(irq_ack[0], 2) || $past(reg_wr, 2) || $past(reg_wr))
    else $error("interrupt fell without service or write");
  a_count_hold: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(count_tick, 2)
    && !$past(reg_wr, 2) |-> $stable(timer_count))
    else $error("count moved without tick or write");
  a_state_cause: assert property ($changed(compare_output_state) |-> $past(count_tick)
    || $past(count_tick, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("output state moved without match or force");
  c_irq: cover property ($rose(compare_irq[0]));
  c_floor: cover property (counter_floor);
  c_limit: cover property (counter_limit);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

// *** bench/t16oc_cpu_model.sv ***
// cpu core model on the byte-wide register port
`timescale 1ns/10ps
module t16oc_cpu_model (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released bus shows inverted values so stale data cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // upper byte must go first through the shared latch
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// *** bench/test_timer16_output_compare.sv ***
// self-checking bench for the timer output compare channels
`timescale 1ns/10ps
module test_timer16_output_compare;
  typedef struct {logic [1:0] act; logic exp;} t16oc_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic count_tick = 1'b0;
  logic [1:0] irq_ack = 2'h0;
  logic [1:0] port_value = 2'h2;
  logic [1:0] pin_direction_bit = 2'h0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [1:0] compare_irq;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] compare_output_state;
  logic [15:0] timer_count;
  logic counter_limit;
  logic counter_floor;
  logic [7:0] rb;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  t16oc_row_s rows [4] = '{'{2'h3, 1'b1}, '{2'h0, 1'b1}, '{2'h2, 1'b0}, '{2'h1, 1'b1}};
  always #5 clk = ~clk;
  t16oc_top u_dut (.clk(clk), .rst_n(rst_n), .count_tick(count_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .compare_irq(compare_irq), .port_value(port_value),
    .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe(pin_oe),
    .compare_output_state(compare_output_state), .timer_count(timer_count),
    .counter_limit(counter_limit), .counter_floor(counter_floor));
  t16oc_cpu_model u_cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    u_cpu.rd(a, rb);
    chk({8'h00, rb}, {8'h00, exp});
  endtask
  // one counter tick, then let the lagging count view settle
  task automatic tick();
    @(posedge clk);
    count_tick <= 1'b1;
    @(posedge clk);
    count_tick <= 1'b0;
    idle(3);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    chk(compare_output_state, 2'h0);
    rd_chk(4'h2, 8'h00);
    u_cpu.wr16(4'h2, 16'h1234);
    rd_chk(4'h2, 8'h34);
    rd_chk(4'h3, 8'h12);
    u_cpu.wr(4'h3, 8'h56);
    u_cpu.wr(4'h4, 8'h78);
    rd_chk(4'h5, 8'h56);
    rd_chk(4'hF, 8'h00);
    foreach (rows[i])
    begin
      u_cpu.wr(4'h6, {6'h00, rows[i].act});
      u_cpu.wr(4'h8, 8'h01);
      idle(3);
      chk(compare_output_state[0], rows[i].exp);
      chk(pin_out[0], (rows[i].act != 2'h0) ? rows[i].exp : port_value[0]);
      rd_chk(4'h7, 8'h00);
      if (i == 0)
      begin
        @(posedge clk);
        pin_direction_bit <= 2'h3;
      end
    end
    chk(pin_oe, 2'h3);
    u_cpu.wr(4'h9, 8'h05);
    u_cpu.wr(4'h8, 8'h01);
    idle(3);
    chk(compare_output_state, 2'h1);
    u_cpu.wr(4'h9, 8'h00);
    u_cpu.wr(4'h6, 8'h11);
    u_cpu.wr16(4'h2, 16'h0012);
    u_cpu.wr16(4'h4, 16'h0013);
    u_cpu.wr16(4'h0, 16'h0010);
    tick();
    tick();
    rd_chk(4'h7, 8'h00);
    tick();
    rd_chk(4'h7, 8'h01);
    chk(compare_irq, 2'h1);
    chk(compare_output_state, 2'h0);
    @(posedge clk);
    irq_ack <= 2'h1;
    @(posedge clk);
    irq_ack <= 2'h0;
    idle(3);
    chk(compare_irq, 2'h0);
    u_cpu.wr16(4'h0, 16'h0012);
    tick();
    tick();
    rd_chk(4'h7, 8'h02);
    chk(compare_output_state, 2'h0);
    u_cpu.wr(4'h7, 8'h00);
    rd_chk(4'h7, 8'h02);
    u_cpu.wr(4'h7, 8'h02);
    rd_chk(4'h7, 8'h00);
    chk(timer_count, 16'h0014);
    rd_chk(4'h0, 8'h14);
    rd_chk(4'h1, 8'h00);
    u_cpu.wr(4'h9, 8'h05);
    u_cpu.wr16(4'h2, 16'h0020);
    rd_chk(4'h2, 8'h20);
    u_cpu.wr(4'h9, 8'h00);
    rd_chk(4'h2, 8'h12);
    u_cpu.wr(4'h9, 8'h05);
    u_cpu.wr16(4'h0, 16'h00FF);
    idle(1);
    chk(counter_limit, 1'b1);
    tick();
    chk(counter_floor, 1'b1);
    u_cpu.wr(4'h9, 8'h00);
    rd_chk(4'h2, 8'h20);
    u_cpu.wr(4'h6, 8'h03);
    u_cpu.wr(4'h8, 8'h01);
    idle(2);
    chk(compare_output_state, 2'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    chk(compare_output_state, 2'h0);
    give_verdict();
  end
endmodule
bind t16oc_top t16oc_checker #(.DW(DW)) u_chk (.clk(clk), .rst_n(rst_n),
  .count_tick(count_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack), .compare_irq(compare_irq),
  .port_value(port_value), .pin_direction_bit(pin_direction_bit), .pin_out(pin_out),
  .pin_oe(pin_oe), .compare_output_state(compare_output_state), .timer_count(timer_count),
  .counter_limit(counter_limit), .counter_floor(counter_floor));
